// ### design/acc_pkg.sv
/*
 * Constants shared by the clock and output configuration block:
 * register offsets, field positions, reset values and serial framing.
 * Assumes one 100 MHz system clock and 8-bit registers in a 13-bit address space.
 */
package acc_pkg;
	localparam int          ADDR_W            = 13;
	localparam int          DATA_W            = 8;
	localparam int          ADC_W             = 14;
	localparam int          CMD_BITS          = 16;
	localparam int          FRAME_BITS        = 24;

	localparam logic [12:0] OFS_SERIAL_EDGE   = 13'h0004;
	localparam logic [12:0] OFS_RAND_WCK      = 13'h0007;
	localparam logic [12:0] OFS_CAL_DELAY     = 13'h001E;
	localparam logic [12:0] OFS_DELAY_LOOP    = 13'h0052;
	localparam logic [12:0] OFS_TIMING_SRC    = 13'h0053;
	localparam logic [12:0] OFS_REF_DIV_LO    = 13'h0054;
	localparam logic [12:0] OFS_OUT_DIV_REFHI = 13'h0055;

	localparam logic [7:0]  RST_SERIAL_EDGE   = 8'h9F;
	localparam logic [7:0]  RST_RAND_WCK      = 8'h62;
	localparam logic [7:0]  RST_CAL_DELAY     = 8'h80;
	localparam logic [7:0]  RST_DELAY_LOOP    = 8'h0A;
	localparam logic [7:0]  RST_TIMING_SRC    = 8'h45;
	localparam logic [7:0]  RST_REF_DIV_LO    = 8'h00;
	localparam logic [7:0]  RST_OUT_DIV_REFHI = 8'h48;

	// Bit positions
	localparam int          B_EDGE_SEL        = 7;
	localparam int          B_WCK_INV         = 7;
	localparam int          B_CAL_DLY_EN      = 6;
	localparam int          B_RAND_EN         = 0;
	localparam int          B_DUTY            = 7;
	localparam int          B_PHASE_HI        = 6;
	localparam int          B_PHASE_LO        = 4;
	localparam int          B_LOOP_OUT_EN     = 3;
	localparam int          B_LOOP_EN         = 2;
	localparam int          B_BUF_EN          = 1;
	localparam int          B_LOOP_RUN        = 0;
	localparam int          B_SRC_PLL         = 4;
	localparam int          B_OUTDIV_HI       = 7;
	localparam int          B_OUTDIV_LO       = 4;
	localparam int          B_REFHI_HI        = 1;
	localparam int          B_REFHI_LO        = 0;

	// Cycles of clk per step of the calibration start delay
	localparam int          CAL_STEP_CYCLES   = 16;
	localparam logic [4:0]  BIT_CNT_MAX       = 5'd24;
endpackage : acc_pkg

// ### design/acc_tick_div.sv
/*
 * Divides a one-cycle tick stream by a programmable ratio.
 * Assumes tick_in is synchronous to clk; ratios 0 and 1 pass every tick.
 */
`timescale 1ns/1ns
module acc_tick_div #(
	parameter int W = 10
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] ratio,
	input  wire logic         tick_in,
	output logic              tick_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         tick_r;
	logic         tick_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = 1'b0;
		if (tick_in) begin
			// Ratio change takes hold at once; a count at or past the new limit wraps on the next tick
			if (ratio <= W'(1) || cnt_r >= ratio - W'(1)) begin
				cnt_nxt  = '0;
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_out = tick_r;
endmodule : acc_tick_div

// ### design/acc_clock_out_cfg.sv
/*
 * Serial-port register file and clock/output configuration of the converter.
 * Assumes serial pins and clock ticks are synchronous to clk (100 MHz),
 * and that the phase-delay and reference-divider enable bits live elsewhere and feed in.
 */
// What this block does
// - Serial output changes on falling clock edge when edge bit set, else rising.
// - In down-conversion mode word clock is inverted when polarity bit set.
// - Output data is randomized when randomizer enable bit is set.
// - Calibration delay enable bit selects programmed delay or ignores it.
// - Calibration start delay grows linearly with the eight-bit setting.
// - Duty-correction bit turns loop duty-cycle correction on.
// - Three-bit phase field shifts output clock in 45-degree steps.
// - Phase selection acts only with phase-delay enable and no decimation.
// - Loop output clock off when its enable is 0; no output then while the loop enable bit is set.
// - Loop enable bit enables the delay-locked loop.
// - Input buffer disabled drops internal_clock_on and stops reference divider ticks and converter output.
// - Loop held in reset while reset bit is 0, runs when 1.
// - Timing source bit picks loop output when 1, external clock when 0.
// - Ten-bit reference divider; 0, 1 and 2 divide by one, other N divides by N.
// - Reference divider acts only while its enable bit is set.
// - Reference divider bypassed while its enable bit is 0.
// - Four-bit output divider; 0 and 1 undivided, default divide by four.
`timescale 1ns/1ns
module acc_clock_out_cfg
	import acc_pkg::*;
#(
	parameter int CAL_STEP = acc_pkg::CAL_STEP_CYCLES
) (
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     sclk,
	input  wire logic                     cs_n,
	input  wire logic                     sdi,
	output logic                          sdo_o,
	output logic                          sdo_oe,
	input  wire logic                     down_conversion_mode,
	input  wire logic                     decimation_used,
	input  wire logic                     phase_delay_enable,
	input  wire logic                     reference_divider_enable,
	input  wire logic                     word_clock_in,
	output logic                          word_clock,
	input  wire logic [acc_pkg::ADC_W-1:0] adc_data_in,
	input  wire logic                     adc_valid_in,
	output logic [acc_pkg::ADC_W-1:0]     adc_data_out,
	output logic                          adc_valid_out,
	input  wire logic                     cal_request,
	output logic                          cal_start,
	input  wire logic                     ref_tick,
	input  wire logic                     vco_tick,
	output logic                          ref_div_tick,
	output logic                          out_div_tick,
	output logic                          timing_from_pll,
	output logic                          internal_clock_on,
	output logic                          duty_correct_on,
	output logic                          loop_enable,
	output logic                          loop_in_reset,
	output logic                          loop_output_clock_on,
	output logic [2:0]                    output_clock_phase_select
);
	import acc_pkg::*;

	function automatic logic [7:0] reg_rst(input logic [12:0] a);
		case (a)
			OFS_SERIAL_EDGE:   reg_rst = RST_SERIAL_EDGE;
			OFS_RAND_WCK:      reg_rst = RST_RAND_WCK;
			OFS_CAL_DELAY:     reg_rst = RST_CAL_DELAY;
			OFS_DELAY_LOOP:    reg_rst = RST_DELAY_LOOP;
			OFS_TIMING_SRC:    reg_rst = RST_TIMING_SRC;
			OFS_REF_DIV_LO:    reg_rst = RST_REF_DIV_LO;
			OFS_OUT_DIV_REFHI: reg_rst = RST_OUT_DIV_REFHI;
			default:           reg_rst = 8'h00;
		endcase
	endfunction : reg_rst

	localparam int NREG = 7;
	localparam logic [12:0] OFS_TAB [NREG] = '{OFS_SERIAL_EDGE, OFS_RAND_WCK,
		OFS_CAL_DELAY, OFS_DELAY_LOOP, OFS_TIMING_SRC, OFS_REF_DIV_LO,
		OFS_OUT_DIV_REFHI};

	// Serial front end
	logic             sclk_d_r;
	logic [4:0]       bit_cnt_r;
	logic [4:0]       bit_cnt_nxt;
	logic [15:0]      in_sh_r;
	logic [15:0]      in_sh_nxt;
	logic             rd_r;
	logic             rd_nxt;
	logic [12:0]      addr_r;
	logic [12:0]      addr_nxt;
	logic [7:0]       out_sh_r;
	logic [7:0]       out_sh_nxt;
	logic             sdo_r;
	logic             sdo_nxt;
	logic             wr_en;
	logic [7:0]       wr_data;
	logic [7:0]       rd_data;
	logic             rise;
	logic             fall;
	logic             upd_edge;
	logic [7:0]       regs_r [NREG];

	assign rise = sclk & ~sclk_d_r;
	assign fall = ~sclk & sclk_d_r;
	// Edge on which read data advances
	assign upd_edge = regs_r[0][B_EDGE_SEL] ? fall : rise;

	always_comb begin
		rd_data = 8'h00;
		for (int i = 0; i < NREG; i++) begin
			// Built from the shifter, not addr_nxt, so no process loop forms
			if ({in_sh_r[11:0], sdi} == OFS_TAB[i]) begin
				rd_data = regs_r[i];
			end
		end
	end

	always_comb begin
		bit_cnt_nxt = bit_cnt_r;
		in_sh_nxt   = in_sh_r;
		rd_nxt      = rd_r;
		addr_nxt    = addr_r;
		out_sh_nxt  = out_sh_r;
		sdo_nxt     = sdo_r;
		wr_en       = 1'b0;
		wr_data     = {in_sh_r[6:0], sdi};
		if (cs_n) begin
			bit_cnt_nxt = '0;
			rd_nxt      = 1'b0;
		end else begin
			// Shift out only after the command word, one bit per edge
			if (upd_edge && rd_r && bit_cnt_r >= 5'(CMD_BITS)) begin
				sdo_nxt    = out_sh_r[7];
				out_sh_nxt = {out_sh_r[6:0], 1'b0};
			end
			if (rise && bit_cnt_r < BIT_CNT_MAX) begin
				in_sh_nxt   = {in_sh_r[14:0], sdi};
				bit_cnt_nxt = bit_cnt_r + 5'd1;
				if (bit_cnt_r == 5'(CMD_BITS - 1)) begin
					rd_nxt     = in_sh_r[14];
					addr_nxt   = {in_sh_r[11:0], sdi};
					out_sh_nxt = rd_data;
				end
				if (bit_cnt_r == 5'(FRAME_BITS - 1) && !rd_r) begin
					wr_en = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_d_r  <= 1'b0;
			bit_cnt_r <= '0;
			in_sh_r   <= '0;
			rd_r      <= 1'b0;
			addr_r    <= '0;
			out_sh_r  <= '0;
			sdo_r     <= 1'b0;
		end else begin
			sclk_d_r  <= sclk;
			bit_cnt_r <= bit_cnt_nxt;
			in_sh_r   <= in_sh_nxt;
			rd_r      <= rd_nxt;
			addr_r    <= addr_nxt;
			out_sh_r  <= out_sh_nxt;
			sdo_r     <= sdo_nxt;
		end
	end

	assign sdo_o  = sdo_r;
	assign sdo_oe = ~cs_n & rd_r & (bit_cnt_r >= 5'(CMD_BITS));

	// Factory bits are stored verbatim; nothing here protects them
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			logic [7:0] reg_nxt;
			always_comb begin
				reg_nxt = regs_r[g];
				if (wr_en && addr_r == OFS_TAB[g]) begin
					reg_nxt = wr_data;
				end
			end
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					regs_r[g] <= reg_rst(OFS_TAB[g]);
				end else begin
					regs_r[g] <= reg_nxt;
				end
			end
		end
	endgenerate

	// Decoded controls
	logic [9:0] ref_ratio;
	logic [9:0] ref_raw;
	logic [3:0] out_ratio;
	logic       out_blocked;

	assign duty_correct_on      = regs_r[3][B_DUTY];
	assign loop_output_clock_on = regs_r[3][B_LOOP_OUT_EN];
	assign loop_enable          = regs_r[3][B_LOOP_EN];
	assign internal_clock_on    = regs_r[3][B_BUF_EN];
	assign loop_in_reset        = ~regs_r[3][B_LOOP_RUN];
	assign timing_from_pll      = regs_r[4][B_SRC_PLL];
	assign output_clock_phase_select =
		(phase_delay_enable && !decimation_used) ?
		regs_r[3][B_PHASE_HI:B_PHASE_LO] : 3'b000;

	assign ref_raw = {regs_r[6][B_REFHI_HI:B_REFHI_LO], regs_r[5]};
	// Ratio two is unsupported and handled as a pass-through
	assign ref_ratio = (!reference_divider_enable || ref_raw == 10'h002)
		? 10'h000 : ref_raw;
	assign out_ratio = regs_r[6][B_OUTDIV_HI:B_OUTDIV_LO];

	acc_tick_div #(.W(10)) u_ref_div (
		.clk      (clk),
		.resetn   (resetn),
		.ratio    (ref_ratio),
		.tick_in  (ref_tick & internal_clock_on),
		.tick_out (ref_div_tick)
	);

	acc_tick_div #(.W(4)) u_out_div (
		.clk      (clk),
		.resetn   (resetn),
		.ratio    (out_ratio),
		.tick_in  (vco_tick),
		.tick_out (out_div_tick)
	);

	// Data path
	logic [ADC_W-1:0] data_r;
	logic [ADC_W-1:0] data_nxt;
	logic             valid_r;
	logic             valid_nxt;
	logic             wck_r;
	logic             wck_nxt;

	assign out_blocked = !internal_clock_on
		|| (loop_enable && (!loop_output_clock_on || loop_in_reset));

	always_comb begin
		data_nxt  = data_r;
		valid_nxt = adc_valid_in & ~out_blocked;
		wck_nxt   = word_clock_in
			^ (down_conversion_mode & regs_r[1][B_WCK_INV]);
		if (valid_nxt) begin
			// Upper bits scrambled by the LSB so the LSB alone undoes it
			data_nxt = regs_r[1][B_RAND_EN] ?
				(adc_data_in ^ {{(ADC_W-1){adc_data_in[0]}}, 1'b0})
				: adc_data_in;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_r  <= '0;
			valid_r <= 1'b0;
			wck_r   <= 1'b0;
		end else begin
			data_r  <= data_nxt;
			valid_r <= valid_nxt;
			wck_r   <= wck_nxt;
		end
	end

	assign adc_data_out  = data_r;
	assign adc_valid_out = valid_r;
	assign word_clock    = wck_r;

	// Calibration start delay
	typedef enum logic [1:0] {ACC_CAL_IDLE, ACC_CAL_WAIT, ACC_CAL_GO}
		acc_cal_t;
	acc_cal_t   cal_st_r;
	acc_cal_t   cal_st_nxt;
	logic [15:0] cal_cnt_r;
	logic [15:0] cal_cnt_nxt;
	logic [15:0] cal_target;

	assign cal_target = regs_r[1][B_CAL_DLY_EN] ?
		16'(32'(regs_r[2]) * CAL_STEP) : 16'h0000;

	always_comb begin
		cal_st_nxt  = cal_st_r;
		cal_cnt_nxt = cal_cnt_r;
		case (cal_st_r)
			ACC_CAL_IDLE: begin
				cal_cnt_nxt = 16'h0000;
				if (cal_request) begin
					cal_st_nxt = ACC_CAL_WAIT;
				end
			end
			ACC_CAL_WAIT: begin
				if (cal_cnt_r >= cal_target) begin
					cal_st_nxt = ACC_CAL_GO;
				end else begin
					cal_cnt_nxt = cal_cnt_r + 16'h0001;
				end
			end
			ACC_CAL_GO: begin
				cal_st_nxt = ACC_CAL_IDLE;
			end
			default: begin
				cal_st_nxt = ACC_CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cal_st_r  <= ACC_CAL_IDLE;
			cal_cnt_r <= 16'h0000;
		end else begin
			cal_st_r  <= cal_st_nxt;
			cal_cnt_r <= cal_cnt_nxt;
		end
	end

	assign cal_start = (cal_st_r == ACC_CAL_GO);
endmodule : acc_clock_out_cfg

// ### testbench/acc_clock_out_cfg_checker.sv
/*
 * Port-level assertions for the clock and output configuration block.
 * Assumes one clock domain and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
module acc_clock_out_cfg_checker (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       decimation_used,
	input wire logic       phase_delay_enable,
	input wire logic       reference_divider_enable,
	input wire logic       adc_valid_in,
	input wire logic       adc_valid_out,
	input wire logic       ref_tick,
	input wire logic       vco_tick,
	input wire logic       ref_div_tick,
	input wire logic       out_div_tick,
	input wire logic       cal_start,
	input wire logic       internal_clock_on,
	input wire logic       loop_enable,
	input wire logic       loop_in_reset,
	input wire logic       loop_output_clock_on,
	input wire logic [2:0] output_clock_phase_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic blocked;
	assign blocked = loop_enable & (~loop_output_clock_on | loop_in_reset);
	sequence s_take;
		adc_valid_in && internal_clock_on && !blocked;
	endsequence
	AST_TAKE: assert property (s_take |=> adc_valid_out)
		else $error("accepted word not passed on");
	AST_BUF_OFF: assert property (!internal_clock_on |=> !adc_valid_out)
		else $error("output while input buffer off");
	AST_LOOP_OFF: assert property (blocked |=> !adc_valid_out)
		else $error("output while loop clock off");
	AST_NO_SPUR: assert property (adc_valid_out |-> $past(adc_valid_in))
		else $error("output word without input word");
	AST_PHASE: assert property ((!phase_delay_enable || decimation_used)
		|-> output_clock_phase_select == 3'h0)
		else $error("phase applied while not allowed");
	AST_BYPASS: assert property (ref_tick && internal_clock_on &&
		!reference_divider_enable |=> ref_div_tick)
		else $error("reference divider not bypassed");
	AST_REF_CAUSE: assert property (ref_div_tick |-> $past(ref_tick))
		else $error("reference tick without input tick");
	AST_OUT_CAUSE: assert property (out_div_tick |-> $past(vco_tick))
		else $error("output divider tick without input tick");
	AST_CAL_PULSE: assert property (cal_start |=> !cal_start)
		else $error("calibration start longer than one cycle");
endmodule : acc_clock_out_cfg_checker

// ### testbench/acc_host_model.sv
/*
 * Behavioural serial host controller for the configuration port.
 * Assumes the device samples its serial pins on clk rising edges.
 */
`timescale 1ns/1ns
module acc_host_model (
	input  wire logic clk,
	output logic      sclk,
	output logic      cs_n,
	output logic      sdi,
	input  wire logic sdo
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi  = 1'b0;
	end
	// Three clk per half period, above the two-sample minimum
	task automatic xfer(input logic [23:0] fr, input logic fall,
		output logic [7:0] rd);
		@(posedge clk);
		cs_n <= 1'b0;
		for (int k = 23; k >= 0; k--) begin
			sdi <= fr[k];
			repeat (3) @(posedge clk);
			// Sampled late in the half period where each mode is stable
			if (fall && k < 8) rd[k] = sdo;
			if (!fall && k < 7) rd[k + 1] = sdo;
			sclk <= 1'b1;
			repeat (3) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (3) @(posedge clk);
		if (!fall) rd[0] = sdo;
		cs_n <= 1'b1;
		// Released line must not keep its last value
		sdi <= ~sdi;
	endtask : xfer
endmodule : acc_host_model

// ### testbench/acc_clock_out_cfg_tb.sv
/*
 * Self-checking bench with a register model and a serial host model.
 * Assumes acc_pkg, the design and the checker are compiled first.
 */
`timescale 1ns/1ns
module acc_clock_out_cfg_tb;
	import acc_pkg::*;
	logic clk, resetn, sclk, cs_n, sdi, sdo_o, sdo_oe, dcm, dec, phen, rden;
	logic wclk_in, wclk, av_in, av_out, cal_req, cal_st, rt, vt, rdt, odt;
	logic tpll, ico, dco, len, lrst, loco;
	logic [ADC_W-1:0] ad_in, ad_out;
	logic [2:0]       ph;
	logic [7:0]       mdl [logic [12:0]];
	logic [7:0]       t52 [4] = '{8'h0A, 8'h08, 8'h06, 8'h0F};
	int               fails, checked, cyc, seed, lat0, lat1, nref, nout;
	// Undriven line reads inverted, so a missing output enable shows up
	acc_host_model host_u (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo_oe ? sdo_o : ~sdo_o));
	acc_clock_out_cfg #(.CAL_STEP(1)) dut_u (.clk(clk), .resetn(resetn),
		.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.down_conversion_mode(dcm), .decimation_used(dec),
		.phase_delay_enable(phen), .reference_divider_enable(rden),
		.word_clock_in(wclk_in), .word_clock(wclk), .adc_data_in(ad_in),
		.adc_valid_in(av_in), .adc_data_out(ad_out), .adc_valid_out(av_out),
		.cal_request(cal_req), .cal_start(cal_st), .ref_tick(rt),
		.vco_tick(vt), .ref_div_tick(rdt), .out_div_tick(odt),
		.timing_from_pll(tpll), .internal_clock_on(ico),
		.duty_correct_on(dco), .loop_enable(len), .loop_in_reset(lrst),
		.loop_output_clock_on(loco), .output_clock_phase_select(ph));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk) begin
		if (rdt === 1'b1) nref++;
		if (odt === 1'b1) nout++;
	end
	// Budget covers about sixty frames plus the divider runs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			close_out;
		end
	end
	task automatic close_out;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] r;
		host_u.xfer({3'b000, a, d}, mdl[OFS_SERIAL_EDGE][7], r);
		if (mdl.exists(a)) mdl[a] = d;
	endtask : wr
	task automatic rdchk(input logic [12:0] a);
		logic [7:0] r;
		host_u.xfer({3'b100, a, 8'h00}, mdl[OFS_SERIAL_EDGE][7], r);
		check("reg_read", r, mdl.exists(a) ? mdl[a] : 8'h00);
	endtask : rdchk
	task automatic cfg;
		logic [7:0] r;
		#1;
		r = mdl[OFS_DELAY_LOOP];
		check("duty", dco, r[7]);
		check("phase", ph, (phen && !dec) ? r[6:4] : 3'h0);
		check("loop_out", loco, r[3]);
		check("loop_en", len, r[2]);
		check("buffer", ico, r[1]);
		check("loop_rst", lrst, !r[0]);
		check("source", tpll, mdl[OFS_TIMING_SRC][4]);
	endtask : cfg
	task automatic stream(input int cnt);
		logic [ADC_W-1:0] d;
		logic [7:0]       r;
		logic             w, e, v;
		r = mdl[OFS_DELAY_LOOP];
		repeat (cnt) begin
			@(posedge clk);
			d = ADC_W'($random(seed));
			{w, e, v} = 3'($random(seed));
			ad_in <= d;
			wclk_in <= w;
			dcm <= e;
			av_in <= v;
			@(posedge clk);
			#1;
			check("word_clock", wclk, w ^ (e & mdl[OFS_RAND_WCK][7]));
			v = v & r[1] & !(r[2] & (!r[3] | !r[0]));
			check("valid", av_out, v);
			if (v) check("data", ad_out, mdl[OFS_RAND_WCK][0] ?
				d ^ {{13{d[0]}}, 1'b0} : d);
		end
	endtask : stream
	task automatic cal(input logic [7:0] dly, input logic en, output int lat);
		wr(OFS_RAND_WCK, {1'b0, en, 6'h22});
		wr(OFS_CAL_DELAY, dly);
		@(posedge clk);
		cal_req <= 1'b1;
		@(posedge clk);
		cal_req <= 1'b0;
		lat = 0;
		while (cal_st !== 1'b1 && lat < 3000) begin
			@(posedge clk);
			#1;
			lat++;
		end
	endtask : cal
	task automatic dv(input logic [9:0] rv, input logic en, input logic [3:0] ov,
		input int t, er, eo);
		wr(OFS_REF_DIV_LO, rv[7:0]);
		wr(OFS_OUT_DIV_REFHI, {ov, RST_OUT_DIV_REFHI[3:2], rv[9:8]});
		rden <= en;
		@(posedge clk);
		nref = 0;
		nout = 0;
		repeat (t) begin
			rt <= 1'b1;
			vt <= 1'b1;
			@(posedge clk);
			rt <= 1'b0;
			vt <= 1'b0;
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
		check("ref_ticks", nref, er);
		check("out_ticks", nout, eo);
	endtask : dv
	initial begin
		seed = 13;
		resetn = 1'b0;
		{dcm, dec, phen, rden, wclk_in, av_in, cal_req, rt, vt} = '0;
		ad_in = '0;
		mdl[OFS_SERIAL_EDGE] = RST_SERIAL_EDGE;
		mdl[OFS_RAND_WCK] = RST_RAND_WCK;
		mdl[OFS_CAL_DELAY] = RST_CAL_DELAY;
		mdl[OFS_DELAY_LOOP] = RST_DELAY_LOOP;
		mdl[OFS_TIMING_SRC] = RST_TIMING_SRC;
		mdl[OFS_REF_DIV_LO] = RST_REF_DIV_LO;
		mdl[OFS_OUT_DIV_REFHI] = RST_OUT_DIV_REFHI;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		foreach (mdl[a]) rdchk(a);
		cfg;
		wr(13'h0010, 8'hA5);
		rdchk(13'h0010);
		for (int n = 0; n < 6; n++) begin
			{phen, dec} <= 2'($random(seed));
			wr(OFS_DELAY_LOOP, 8'($random(seed)));
			cfg;
		end
		wr(OFS_DELAY_LOOP, 8'h0E);
		cfg;
		wr(OFS_DELAY_LOOP, 8'h0F);
		cfg;
		wr(OFS_TIMING_SRC, RST_TIMING_SRC | 8'h10);
		cfg;
		wr(OFS_SERIAL_EDGE, 8'h1F);
		rdchk(OFS_TIMING_SRC);
		rdchk(OFS_SERIAL_EDGE);
		wr(OFS_SERIAL_EDGE, RST_SERIAL_EDGE);
		rdchk(OFS_DELAY_LOOP);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DELAY_LOOP, t52[i]);
			wr(OFS_RAND_WCK, i[0] ? 8'hE3 : RST_RAND_WCK);
			stream(8);
		end
		cal(8'd4, 1'b1, lat0);
		cal(8'd12, 1'b1, lat1);
		check("cal_slope", 32'(lat1 - lat0), 32'd8);
		cal(8'd0, 1'b1, lat0);
		cal(8'd200, 1'b0, lat1);
		check("cal_ignored", 32'(lat1), 32'(lat0));
		wr(OFS_DELAY_LOOP, RST_DELAY_LOOP);
		// Ratio two is never programmed by the host
		dv(10'd5, 1'b0, 4'h4, 4, 4, 1);
		dv(10'd1, 1'b1, 4'h4, 4, 4, 1);
		dv(10'd0, 1'b1, 4'h4, 4, 4, 1);
		dv(10'd3, 1'b1, 4'h4, 12, 4, 3);
		dv(10'd5, 1'b1, 4'h4, 20, 4, 5);
		dv(10'd260, 1'b1, 4'h4, 520, 2, 130);
		dv(10'd5, 1'b0, 4'h0, 4, 4, 4);
		dv(10'd5, 1'b0, 4'h1, 4, 4, 4);
		dv(10'd5, 1'b0, 4'hF, 15, 15, 1);
		close_out;
	end
endmodule : acc_clock_out_cfg_tb
bind acc_clock_out_cfg acc_clock_out_cfg_checker chk_u (.clk(clk),
	.resetn(resetn), .decimation_used(decimation_used),
	.phase_delay_enable(phase_delay_enable),
	.reference_divider_enable(reference_divider_enable),
	.adc_valid_in(adc_valid_in), .adc_valid_out(adc_valid_out),
	.ref_tick(ref_tick), .vco_tick(vco_tick), .ref_div_tick(ref_div_tick),
	.out_div_tick(out_div_tick), .cal_start(cal_start),
	.internal_clock_on(internal_clock_on), .loop_enable(loop_enable),
	.loop_in_reset(loop_in_reset),
	.loop_output_clock_on(loop_output_clock_on),
	.output_clock_phase_select(output_clock_phase_select));
